// ---- design/tap_pkg.sv ----
// Constants and types shared by the test access port controller.
// Assumes a single system clock that oversamples the probe pins.
package tap_pkg;

    localparam int unsigned IR_W     = 4;
    localparam int unsigned TMS_RSTN = 5;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_INTEST = 4'h1;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] IR_ABORT  = 4'h8;
    localparam logic [IR_W-1:0] IR_DPACC  = 4'ha;
    localparam logic [IR_W-1:0] IR_APACC  = 4'hb;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'he;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPT   = 4'h1;

    // Arbitrary identification value, bit 0 set as the standard demands
    localparam logic [31:0] IDCODE_VAL = 32'h0000_1001;

    typedef enum logic [3:0] {
        TLR  = 4'hf,
        RTI  = 4'hc,
        SDS  = 4'h7,
        CDR  = 4'h6,
        SHDR = 4'h2,
        E1DR = 4'h1,
        PDR  = 4'h3,
        E2DR = 4'h0,
        UDR  = 4'h5,
        SIS  = 4'h4,
        CIR  = 4'he,
        SHIR = 4'ha,
        E1IR = 4'h9,
        PIR  = 4'hb,
        E2IR = 4'h8,
        UIR  = 4'hd
    } tap_state_t;

endpackage : tap_pkg

// ---- design/jtag_tap_controller.sv ----
// Test access port controller with instruction, bypass, identity and
// sample chains, and a FIFO that carries updated sample words outward.
// Assumes tck, tms, tdi arrive asynchronously and are oversampled by clk.
//
// Operation
// - Test reset low forces Test-Logic-Reset asynchronously and holds it there.
// - Entering Test-Logic-Reset loads the identity instruction.
// - Power-on reset also forces Test-Logic-Reset.
// - Mode select sampled at rising tck chooses the next state.
// - Five rising edges with mode select high reach Test-Logic-Reset.
// - Serial input sampled at rising tck enters the selected chain.
// - Serial output changes on falling tck.
// - Serial output undriven unless a chain is shifting out.
// - State picks instruction or data chain; instruction picks the data chain.
// - Unimplemented instruction codes act as bypass.
// - External and internal test instructions act as bypass and capture, shift and update no other chain.
// - Capture loads in parallel; shift moves one bit per tck toward output.
// - Update moves the chain into its parallel register, else held.
// - Stopped tck leaves state and registers unchanged, except the pending update word, which still drains into the FIFO.
// - The instruction chain is four bits wide.
// - Decoder knows bypass, identity, sample, both tests, and three debug codes.
// - Debug instructions steer the output multiplexer to the core controller.

// ----------------------------------------------------------------
// Shift-register FIFO: head entry is a flop, so outputs are registered
// ----------------------------------------------------------------
module tap_fifo #(
    parameter int unsigned W = 16,
    parameter int unsigned D = 32
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [D-1:0]        vld;
    } fifo_t;

    fifo_t s;
    fifo_t next_s;
    logic  pop;
    logic  push;

    assign in_ready  = ~s.vld[D-1];
    assign out_valid = s.vld[0];
    assign out_data  = s.mem[0];
    assign pop       = s.vld[0] & out_ready;
    assign push      = in_valid & in_ready;

    always_comb
    begin
        next_s = s;
        for (int i = 0; i < D; i++)
        begin
            if (pop)
            begin
                next_s.mem[i] = (i < D - 1) ? s.mem[(i + 1) % D] : s.mem[i];
                next_s.vld[i] = (i < D - 1) ? s.vld[(i + 1) % D] : 1'b0;
            end
        end
        // Write the first free slot after any shift
        for (int i = D - 1; i >= 0; i--)
        begin
            if (push && !next_s.vld[i] && (i == 0 || next_s.vld[(i + D - 1) % D]))
            begin
                next_s.mem[i] = in_data;
                next_s.vld[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end

    a_fifo_order : assert property (@(posedge clk) disable iff (!nrst)
        (s.vld[1] |-> s.vld[0]))
        else $error("fifo holes in valid chain");

endmodule : tap_fifo

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module jtag_tap_controller
    import tap_pkg::*;
#(
    parameter int unsigned BSR_W = 16,
    parameter int unsigned FIFO_D = 32
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             trst_n,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic             core_tdo,
    input  wire logic [BSR_W-1:0] sample_in,
    output logic                  tdo,
    output logic                  tdo_oe,
    output logic                  tdo_sel,
    output logic [tap_pkg::IR_W-1:0] ir_out,
    output logic                  bnd_valid,
    input  wire logic             bnd_ready,
    output logic [BSR_W-1:0]      bnd_data
);
    import tap_pkg::*;

    typedef struct packed {
        logic [2:0]       tck_sy;
        logic [1:0]       tms_sy;
        logic [1:0]       tdi_sy;
        tap_state_t       tap;
        logic [IR_W-1:0]  ir_sh;
        logic [IR_W-1:0]  ir;
        logic             byp;
        logic [31:0]      id_sh;
        logic [BSR_W-1:0] bs_sh;
        logic             pend;
        logic [BSR_W-1:0] pend_data;
        logic             tdo;
        logic             tdo_oe;
        logic             tdo_sel;
    } state_t;

    localparam state_t RST_S = '{tap: TLR, ir: IR_IDCODE, ir_sh: IR_CAPT, default: '0};

    state_t s;
    state_t next_s;
    logic   arst_n;
    logic   rise;
    logic   fall;
    logic   in_ready;
    logic   sel_id;
    logic   sel_bs;
    logic   sel_core;
    logic   chain_lsb;

    // ------------------------------------------------------------
    // Next state of the port state machine
    // ------------------------------------------------------------
    // every path reaches reset within five high samples
    function automatic tap_state_t tap_next(input tap_state_t st, input logic m);
        case (st)
            TLR:     tap_next = m ? TLR  : RTI;
            RTI:     tap_next = m ? SDS  : RTI;
            SDS:     tap_next = m ? SIS  : CDR;
            CDR:     tap_next = m ? E1DR : SHDR;
            SHDR:    tap_next = m ? E1DR : SHDR;
            E1DR:    tap_next = m ? UDR  : PDR;
            PDR:     tap_next = m ? E2DR : PDR;
            E2DR:    tap_next = m ? UDR  : SHDR;
            UDR:     tap_next = m ? SDS  : RTI;
            SIS:     tap_next = m ? TLR  : CIR;
            CIR:     tap_next = m ? E1IR : SHIR;
            SHIR:    tap_next = m ? E1IR : SHIR;
            E1IR:    tap_next = m ? UIR  : PIR;
            PIR:     tap_next = m ? E2IR : PIR;
            E2IR:    tap_next = m ? UIR  : SHIR;
            UIR:     tap_next = m ? SDS  : RTI;
            default: tap_next = TLR;
        endcase
    endfunction : tap_next

    // either reset forces the start state
    assign arst_n = nrst & trst_n;

    // Edges come from the settled sync stages only
    assign rise = s.tck_sy[1] & ~s.tck_sy[2];
    assign fall = ~s.tck_sy[1] & s.tck_sy[2];

    // decode; every other code falls to bypass
    assign sel_id   = (s.ir == IR_IDCODE);
    assign sel_bs   = (s.ir == IR_SAMPLE);
    assign sel_core = (s.ir == IR_APACC) | (s.ir == IR_DPACC) | (s.ir == IR_ABORT);

    // state picks the IR chain, instruction picks the DR chain
    always_comb
    begin
        chain_lsb = s.byp;
        if (s.tap == SHIR)
            chain_lsb = s.ir_sh[0];
        else if (sel_id)
            chain_lsb = s.id_sh[0];
        else if (sel_bs)
            chain_lsb = s.bs_sh[0];
    end

    always_comb
    begin
        next_s = s;
        next_s.tck_sy = {s.tck_sy[1:0], tck};
        next_s.tms_sy = {s.tms_sy[0], tms};
        next_s.tdi_sy = {s.tdi_sy[0], tdi};
        if (s.pend && in_ready)
            next_s.pend = 1'b0;
        // nothing below moves without a tck edge
        if (rise)
        begin
            // next state from sampled mode select
            next_s.tap = tap_next(s.tap, s.tms_sy[1]);
            // load on the edge that enters reset, so no stale code is seen there
            if (next_s.tap == TLR)
                next_s.ir = IR_IDCODE;
            case (s.tap)
                CIR:
                    next_s.ir_sh = IR_CAPT;
                SHIR:
                    next_s.ir_sh = {s.tdi_sy[1], s.ir_sh[IR_W-1:1]};
                UIR:
                    next_s.ir = s.ir_sh;
                CDR:
                begin
                    next_s.byp = 1'b0;
                    if (sel_id)
                        next_s.id_sh = IDCODE_VAL;
                    if (sel_bs)
                        next_s.bs_sh = sample_in;
                end
                // bypass shifts under every instruction, identity and sample chains only when selected; test modes use bypass
                SHDR:
                begin
                    next_s.byp = s.tdi_sy[1];
                    if (sel_id)
                        next_s.id_sh = {s.tdi_sy[1], s.id_sh[31:1]};
                    if (sel_bs)
                        next_s.bs_sh = {s.tdi_sy[1], s.bs_sh[BSR_W-1:1]};
                end
                // updated sample word queued to the boundary cells
                UDR:
                begin
                    if (sel_bs)
                    begin
                        next_s.pend      = 1'b1;
                        next_s.pend_data = s.bs_sh;
                    end
                end
                default:
                    next_s.tap = next_s.tap;
            endcase
        end
        // output side moves on the falling edge
        if (fall)
        begin
            next_s.tdo_oe  = (s.tap == SHDR) | (s.tap == SHIR);
            next_s.tdo_sel = sel_core;
            next_s.tdo     = 1'b0;
            if (next_s.tdo_oe)
                next_s.tdo = (sel_core && s.tap == SHDR) ? core_tdo : chain_lsb;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            s <= RST_S;
        else
            s <= next_s;
    end

    // ------------------------------------------------------------
    // Outward queue: a full queue holds the pending word, so one
    // further update before it drains replaces it
    // ------------------------------------------------------------
    tap_fifo #(
        .W (BSR_W),
        .D (FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (s.pend),
        .in_ready  (in_ready),
        .in_data   (s.pend_data),
        .out_valid (bnd_valid),
        .out_ready (bnd_ready),
        .out_data  (bnd_data)
    );

    assign tdo     = s.tdo;
    assign tdo_oe  = s.tdo_oe;
    assign tdo_sel = s.tdo_sel;
    assign ir_out  = s.ir;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [2:0] hi_cnt;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hi_cnt <= 3'h0;
        else if (rise)
            hi_cnt <= !s.tms_sy[1] ? 3'h0 : (hi_cnt == 3'h7 ? hi_cnt : hi_cnt + 3'h1);
    end

    default clocking cb @(posedge clk); endclocking
    // Test reset jumps the state asynchronously, so history checks pause with it
    default disable iff (!arst_n);

    a_trst_tlr : assert property (disable iff (!nrst) !trst_n |-> s.tap == TLR)
        else $error("state left reset while test reset low");
    a_tlr_idcode : assert property (rise && s.tap == TLR |=> s.ir == IR_IDCODE)
        else $error("reset state did not load identity code");
    a_tlr_entry : assert property (rise && tap_next(s.tap, s.tms_sy[1]) == TLR
        |=> s.ir == IR_IDCODE)
        else $error("entering reset did not load identity code");
    a_tms_five : assert property (rise && s.tms_sy[1] && hi_cnt >= 3'(TMS_RSTN - 1)
        |=> s.tap == TLR)
        else $error("five high mode samples missed reset");
    a_tck_stop : assert property (!rise |=> $stable(s.tap) && $stable(s.ir))
        else $error("state moved without rising tck");
    a_tdo_fall : assert property ($changed(s.tdo) || $changed(s.tdo_oe) |-> $past(fall))
        else $error("serial output moved off falling tck");
    a_oe_idle : assert property (fall && s.tap != SHDR && s.tap != SHIR |=> !s.tdo_oe)
        else $error("output enabled outside shift");
    a_byp_delay : assert property (rise && s.tap == SHDR |=> s.byp == $past(s.tdi_sy[1]))
        else $error("bypass flop not one tck delay");
    a_test_hold : assert property (rise && (s.ir == IR_EXTEST || s.ir == IR_INTEST)
        |=> $stable(s.bs_sh) && $stable(s.id_sh) && !$rose(s.pend))
        else $error("test instruction touched a chain");
    a_core_sel : assert property (fall && sel_core |=> tdo_sel)
        else $error("debug instruction did not steer output");
    a_upd_push : assert property (rise && s.tap == UDR && sel_bs |=> s.pend)
        else $error("update did not queue sample word");

    c_ir_load : cover property (rise && s.tap == UIR);
    c_id_shift : cover property (rise && s.tap == SHDR && sel_id);
    c_fifo_full : cover property (s.pend && !in_ready);
    c_tms_reset : cover property (rise && hi_cnt == 3'(TMS_RSTN - 1) && s.tap != TLR);

endmodule : jtag_tap_controller

// ---- verification/tap_probe.sv ----
// Probe model: drives the link pins and reads the serial output pin.
// Assumes the bench calls tick; the link clock stands still between calls.
module tap_probe (
    input  wire logic clk,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_tdo;
    // Pull-up holds the pin high while the device leaves it undriven
    assign pin_tdo = tdo_oe ? tdo : 1'b1;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (4) @(negedge clk);
        q = pin_tdo;
        tck = 1'b0;
    endtask : tick
endmodule : tap_probe

// ---- verification/jtag_tap_controller_bench.sv ----
// Bench for the test access port controller, scans driven through the probe.
// Assumes the package, the design and the probe model are compiled first.
module jtag_tap_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tap_pkg::*;
    logic            clk, nrst, trst_n, core_tdo, tck, tms, tdi;
    logic            tdo, tdo_oe, tdo_sel, bnd_valid, bnd_ready, q;
    logic [IR_W-1:0] ir_out;
    logic [15:0]     sample_in, bnd_data;
    logic [31:0]     rd;
    int              n_fail, samples_checked;

    jtag_tap_controller #(.BSR_W(16), .FIFO_D(32)) i_jtag_tap_controller (
        .clk(clk), .nrst(nrst), .trst_n(trst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .core_tdo(core_tdo), .sample_in(sample_in), .tdo(tdo), .tdo_oe(tdo_oe),
        .tdo_sel(tdo_sel), .ir_out(ir_out), .bnd_valid(bnd_valid),
        .bnd_ready(bnd_ready), .bnd_data(bnd_data));
    tap_probe i_tap_probe (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
        .tms(tms), .tdi(tdi));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // Starts and ends in Run-Test/Idle; LSB of din enters first
    task automatic scan(input logic ir, input int n, input logic [31:0] din);
        rd = '0;
        i_tap_probe.tick(1'b1, 1'b1, q);
        if (ir)
            i_tap_probe.tick(1'b1, 1'b1, q);
        i_tap_probe.tick(1'b0, 1'b1, q);
        i_tap_probe.tick(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            i_tap_probe.tick(logic'(i == n - 1), din[i], q);
            rd[i] = q;
        end
        i_tap_probe.tick(1'b1, 1'b1, q);
        i_tap_probe.tick(1'b0, 1'b1, q);
        repeat (8) @(negedge clk);
    endtask : scan

    task automatic load(input logic [IR_W-1:0] code);
        scan(1'b1, IR_W, 32'(code));
        check("ir capture", rd, 32'(IR_CAPT));
        check("ir", ir_out, code);
    endtask : load

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_idcode;
        check("reset ir", ir_out, IR_IDCODE);
        check("idle oe", tdo_oe, 1'b0);
        i_tap_probe.tick(1'b0, 1'b1, q);
        scan(1'b0, 32, 32'h0);
        check("idcode", rd, IDCODE_VAL);
        check("oe after", tdo_oe, 1'b0);
    endtask : t_idcode

    task automatic t_bypass;
        logic [IR_W-1:0] codes [4] = '{IR_BYPASS, 4'h5, IR_EXTEST, IR_INTEST};
        foreach (codes[k])
        begin
            load(codes[k]);
            scan(1'b0, 8, 32'h5a);
            check("bypass path", rd, 32'hb4);
            check("no push", bnd_valid, 1'b0);
            check("own source", tdo_sel, 1'b0);
            repeat (200) @(negedge clk);
            check("stopped ir", ir_out, codes[k]);
        end
    endtask : t_bypass

    task automatic t_debug;
        logic [IR_W-1:0] codes [3] = '{IR_ABORT, IR_DPACC, IR_APACC};
        foreach (codes[k])
        begin
            core_tdo = logic'(k != 1);
            load(codes[k]);
            check("core source", tdo_sel, 1'b1);
            scan(1'b0, 8, 32'h0);
            check("core data", rd, {24'h0, {8{core_tdo}}});
        end
        load(IR_IDCODE);
        check("own again", tdo_sel, 1'b0);
    endtask : t_debug

    task automatic t_tms_reset;
        load(IR_BYPASS);
        i_tap_probe.tick(1'b1, 1'b1, q);
        i_tap_probe.tick(1'b0, 1'b1, q);
        i_tap_probe.tick(1'b0, 1'b1, q);
        repeat (5) i_tap_probe.tick(1'b1, 1'b1, q);
        repeat (8) @(negedge clk);
        check("tms reset ir", ir_out, IR_IDCODE);
        i_tap_probe.tick(1'b0, 1'b1, q);
        scan(1'b0, 32, 32'h0);
        check("tms reset id", rd, IDCODE_VAL);
    endtask : t_tms_reset

    task automatic t_trst;
        load(IR_BYPASS);
        trst_n = 1'b0;
        repeat (3) i_tap_probe.tick(1'b0, 1'b1, q);
        check("trst ir", ir_out, IR_IDCODE);
        trst_n = 1'b1;
        repeat (4) @(negedge clk);
        i_tap_probe.tick(1'b0, 1'b1, q);
        scan(1'b0, 32, 32'h0);
        check("trst held", rd, IDCODE_VAL);
    endtask : t_trst

    task automatic t_sample_fifo;
        load(IR_SAMPLE);
        for (int i = 0; i < 33; i++)
        begin
            scan(1'b0, 16, 32'(i));
            if (i == 0)
                check("sample capture", rd, 32'hc3a5);
        end
        for (int i = 0; i < 33; i++)
        begin
            for (int k = 0; k < 40 && bnd_valid !== 1'b1; k++)
                @(negedge clk);
            if (bnd_valid !== 1'b1)
            begin
                n_fail++;
                final_report();
            end
            check("update word", bnd_data, 32'(i));
            bnd_ready = 1'b1;
            @(negedge clk);
            bnd_ready = 1'b0;
            @(negedge clk);
        end
        repeat (4) @(negedge clk);
        check("drained", bnd_valid, 1'b0);
    endtask : t_sample_fifo

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        nrst = 1'b0;
        trst_n = 1'b1;
        core_tdo = 1'b0;
        bnd_ready = 1'b0;
        sample_in = 16'hc3a5;
        n_fail = 0;
        samples_checked = 0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_idcode();
        t_bypass();
        t_debug();
        t_tms_reset();
        t_trst();
        t_sample_fifo();
        final_report();
    end
endmodule : jtag_tap_controller_bench
